// ---- rtl/range_ctrl_pkg.sv ----
package range_ctrl_pkg;
	localparam int NREG = 25;
	localparam int IDX_CTRL = 11;
	localparam int IDX_RANGE = 23;
	localparam int IDX_STAT = 24;
	localparam logic [NREG-1:0][11:0] REG_OFFS = {
		12'h7f4, 12'h7f0, 12'h734, 12'h730, 12'h72c, 12'h728, 12'h724, 12'h720,
		12'h71c, 12'h718, 12'h714, 12'h710, 12'h70c, 12'h708, 12'h704, 12'h700,
		12'h6bc, 12'h6b8, 12'h6b0, 12'h6ac, 12'h6a8, 12'h6a4, 12'h6a0, 12'h69c,
		12'h698};
	localparam logic [NREG-1:0][15:0] REG_RESET = {
		16'h0000, 16'h0000, 16'h0001, 16'h2baf, 16'h0001, 16'he1f8, 16'h00ff,
		16'he1f8, 16'h00ff, 16'h77bf, 16'h000b, 16'h77bf, 16'h000b, 16'h0080,
		16'hfac1, 16'h00ff, 16'h0000, 16'h0100, 16'h640c, 16'h0000, 16'h2c3f,
		16'hf95b, 16'hcb0f, 16'hfe56, 16'h0f04};
	localparam logic [NREG-1:0][15:0] REG_MASK = {
		16'h0000, 16'h0001, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff, 16'h07ff,
		16'hffff, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff, 16'h07ff, 16'h3fff,
		16'hffff, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff, 16'h07ff, 16'hffff,
		16'hffff, 16'hffff, 16'hffff, 16'hffff};
	localparam logic [15:0] RIGHT_AVG_LO = 16'h2baf;
	localparam int DONE_BIT = 15;
	localparam int DLY_LSB = 8;
	localparam int DLY_W = 6;
	localparam int KEEP_BIT = 7;
	localparam int MAX_BIT = 6;
	localparam int MIN_BIT = 5;
	localparam int NOISE_BIT = 4;
	localparam int PEAK_BIT = 3;
	localparam int DLY_BIT = 2;
	localparam int LIM_BIT = 1;
	localparam int EXP_BIT = 0;
	localparam logic [5:0] DLY_CAP = 6'h30;
	localparam int DLY_UNIT = 8;
	localparam int DLY_DEPTH = 384;
	localparam int COEF_FRAC = 24;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic signed [31:0] GAIN_FLOOR = 32'shf0000000;

	typedef struct packed {
		logic [NREG-1:0][15:0] regs;
		logic                  awrdy;
		logic                  wrdy;
		logic                  arrdy;
		logic                  aw_ok;
		logic                  w_ok;
		logic [11:0]           awaddr;
		logic [15:0]           wdata;
		logic [1:0]            wstrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic [8:0]            wp;
		logic [8:0]            drain;
		logic                  done;
		logic [1:0][33:0]      lvl;
		logic signed [31:0]    gain;
		logic                  exp_reg;
		logic                  lim_act;
		logic                  vld;
		logic [23:0]           left;
		logic [23:0]           right;
	} state_s;
endpackage

// ---- rtl/dynamic_range_ctrl_regs.sv ----
`timescale 1ns/10ps
module dynamic_range_ctrl_regs #(
	parameter logic [33:0]        NOISE_LEVEL = 34'h000000100,
	parameter logic [33:0]        LIMIT_LEVEL = 34'h000400000,
	parameter logic signed [31:0] LIMIT_CUT   = 32'shff000000
) (
	input  wire logic        REF_CLK_IN,      // 40 MHz clock
	input  wire logic        RST_N_IN,        // Async reset, active low
	input  wire logic        CE_IN,           // Clock enable, freezes state when low
	input  wire logic [11:0] AWADDR_IN,       // Write address
	input  wire logic        AWVALID_IN,      // Write address valid
	output logic             AWREADY_OUT,     // Write address ready
	input  wire logic [31:0] WDATA_IN,        // Write data
	input  wire logic [3:0]  WSTRB_IN,        // Write strobes
	input  wire logic        WVALID_IN,       // Write data valid
	output logic             WREADY_OUT,      // Write data ready
	output logic [1:0]       BRESP_OUT,       // Write response
	output logic             BVALID_OUT,      // Write response valid
	input  wire logic        BREADY_IN,       // Write response ready
	input  wire logic [11:0] ARADDR_IN,       // Read address
	input  wire logic        ARVALID_IN,      // Read address valid
	output logic             ARREADY_OUT,     // Read address ready
	output logic [31:0]      RDATA_OUT,       // Read data
	output logic [1:0]       RRESP_OUT,       // Read response
	output logic             RVALID_OUT,      // Read data valid
	input  wire logic        RREADY_IN,       // Read data ready
	input  wire logic        SAMPLE_VALID_IN, // One-cycle sample strobe
	input  wire logic [23:0] LEFT_IN,         // Left sample, signed
	input  wire logic [23:0] RIGHT_IN,        // Right sample, signed
	output logic             SAMPLE_VALID_OUT,// Output sample strobe
	output logic [23:0]      LEFT_OUT,        // Left sample out
	output logic [23:0]      RIGHT_OUT,       // Right sample out
	output logic [31:0]      GAIN_OUT         // Smoothed log2 gain, 8.24
);

	range_ctrl_pkg::state_s s;
	range_ctrl_pkg::state_s next_s;
	logic                   rst_meta;
	logic                   rst_sync;
	logic [47:0]            mem [0:range_ctrl_pkg::DLY_DEPTH-1];
	logic [8:0]             rd_ptr;
	logic [8:0]             dly_len;
	logic [47:0]            delayed;

	function automatic logic [5:0] decode(input logic [11:0] a);
		logic [5:0] r;
		r = 6'h3f;
		for (int i = 0; i < range_ctrl_pkg::NREG; i++) begin
			if (range_ctrl_pkg::REG_OFFS[i][11:2] == a[11:2]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction

	// Joins a high/low pair into one 3.24 coefficient.
	function automatic logic [26:0] coef(input logic [15:0] hi, input logic [15:0] lo);
		return {hi[10:0], lo};
	endfunction

	function automatic logic signed [33:0] mul324(input logic signed [33:0] x,
			input logic [26:0] c);
		logic signed [61:0] p;
		p = x * $signed({1'b0, c});
		return 34'(p >>> range_ctrl_pkg::COEF_FRAC);
	endfunction

	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Delay length, codes at or above the cap give the longest delay.
	always_comb begin
		logic [5:0] code;
		code = s.regs[range_ctrl_pkg::IDX_CTRL][range_ctrl_pkg::DLY_LSB +: range_ctrl_pkg::DLY_W];
		if (code >= range_ctrl_pkg::DLY_CAP) begin
			dly_len = 9'(range_ctrl_pkg::DLY_DEPTH);
		end else begin
			dly_len = 9'((code + 6'h01) * range_ctrl_pkg::DLY_UNIT);
		end
		if (s.wp >= dly_len) begin
			rd_ptr = s.wp - dly_len;
		end else begin
			rd_ptr = 9'(s.wp + range_ctrl_pkg::DLY_DEPTH - dly_len);
		end
	end

	// The read sees the old word even at full length, where it equals the write slot.
	assign delayed = mem[rd_ptr];

	always_ff @(posedge REF_CLK_IN) begin
		if (CE_IN && SAMPLE_VALID_IN) begin
			mem[s.wp] <= {LEFT_IN, RIGHT_IN};
		end
	end

	always_comb begin
		logic [5:0]         idx;
		logic [15:0]        ctl;
		logic               range_on;
		logic               use_dly;
		logic [47:0]        pick;
		logic [1:0][23:0]   smp;
		logic [1:0][23:0]   outp;
		logic signed [33:0] ax;
		logic [26:0]        atk;
		logic [26:0]        rel;
		logic [26:0]        avg;
		logic [33:0]        lmax;
		logic               noise;
		logic signed [31:0] tgt;
		logic signed [31:0] gmax;
		logic signed [31:0] gmin;
		logic [26:0]        sc;
		logic [26:0]        hpg;
		logic signed [33:0] prod;
		idx = 6'h3f;
		ctl = s.regs[range_ctrl_pkg::IDX_CTRL];
		range_on = s.regs[range_ctrl_pkg::IDX_RANGE][0];
		use_dly = 1'b0;
		pick = 48'h0;
		smp = '0;
		outp = '0;
		ax = '0;
		atk = '0;
		rel = '0;
		avg = '0;
		lmax = '0;
		noise = 1'b0;
		tgt = '0;
		gmax = '0;
		gmin = '0;
		sc = '0;
		hpg = '0;
		prod = '0;
		next_s = s;

		if (AWVALID_IN && s.awrdy) begin
			next_s.aw_ok = 1'b1;
			next_s.awaddr = AWADDR_IN;
		end
		if (WVALID_IN && s.wrdy) begin
			next_s.w_ok = 1'b1;
			next_s.wdata = WDATA_IN[15:0];
			next_s.wstrb = WSTRB_IN[1:0];
		end
		if (s.bvalid && BREADY_IN) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_ok && s.w_ok && !s.bvalid) begin
			idx = decode(s.awaddr);
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (idx == 6'h3f) ? range_ctrl_pkg::RESP_SLVERR
				: range_ctrl_pkg::RESP_OKAY;
			if (idx != 6'h3f) begin
				for (int b = 0; b < 2; b++) begin
					if (s.wstrb[b]) begin
						next_s.regs[idx][b*8 +: 8] = s.wdata[b*8 +: 8]
							& range_ctrl_pkg::REG_MASK[idx][b*8 +: 8];
					end
				end
			end
		end
		if (s.rvalid && RREADY_IN) begin
			next_s.rvalid = 1'b0;
		end
		if (ARVALID_IN && s.arrdy) begin
			idx = decode(ARADDR_IN);
			next_s.rvalid = 1'b1;
			next_s.rresp = range_ctrl_pkg::RESP_OKAY;
			next_s.rdata = {16'h0, s.regs[idx[4:0]]};
			if (idx == 6'h3f) begin
				next_s.rresp = range_ctrl_pkg::RESP_SLVERR;
				next_s.rdata = 32'h0;
			end else if (idx == 6'(range_ctrl_pkg::IDX_CTRL)) begin
				next_s.rdata[range_ctrl_pkg::DONE_BIT] = s.done
					&& ctl[range_ctrl_pkg::DLY_BIT] && !range_on;
			end else if (idx == 6'(range_ctrl_pkg::IDX_STAT)) begin
				next_s.rdata = {30'h0, s.lim_act, s.exp_reg};
			end
		end
		next_s.awrdy = !next_s.aw_ok && !next_s.bvalid;
		next_s.wrdy = !next_s.w_ok && !next_s.bvalid;
		next_s.arrdy = !next_s.rvalid;

		next_s.vld = 1'b0;
		// Drain runs only with delay on and range control off. The flag drops without
		// waiting for a sample, one cycle after the delay enable clears; the read of bit 15 masks it for that cycle.
		if (!ctl[range_ctrl_pkg::DLY_BIT] || range_on) begin
			next_s.drain = 9'h0;
			next_s.done = 1'b0;
		end else if (SAMPLE_VALID_IN && !s.done) begin
			next_s.drain = s.drain + 9'h1;
			next_s.done = (s.drain + 9'h1) >= dly_len;
		end
		if (SAMPLE_VALID_IN) begin
			next_s.wp = (s.wp == 9'(range_ctrl_pkg::DLY_DEPTH - 1)) ? 9'h0 : s.wp + 9'h1;
			use_dly = ctl[range_ctrl_pkg::DLY_BIT]
				&& !(s.done && !ctl[range_ctrl_pkg::KEEP_BIT]);
			pick = use_dly ? delayed : {LEFT_IN, RIGHT_IN};
			smp[1] = pick[47:24];
			smp[0] = pick[23:0];

			for (int c = 0; c < 2; c++) begin
				ax = 34'($signed(smp[c]));
				if (ax < 0) begin
					ax = -ax;
				end
				atk = (c == 1) ? coef(s.regs[12], s.regs[13]) : coef(s.regs[14], s.regs[15]);
				rel = (c == 1) ? coef(s.regs[16], s.regs[17]) : coef(s.regs[18], s.regs[19]);
				avg = (c == 1) ? coef(s.regs[20], s.regs[21])
					: coef(s.regs[22], range_ctrl_pkg::RIGHT_AVG_LO);
				if (ctl[range_ctrl_pkg::PEAK_BIT]) begin
					if (ax > $signed(s.lvl[c])) begin
						next_s.lvl[c] = $signed(s.lvl[c]) + mul324(ax - $signed(s.lvl[c]), atk);
					end else begin
						next_s.lvl[c] = mul324($signed(s.lvl[c]), rel);
					end
				end else begin
					next_s.lvl[c] = $signed(s.lvl[c]) + mul324(ax - $signed(s.lvl[c]), avg);
				end
			end
			lmax = (next_s.lvl[1] > next_s.lvl[0]) ? next_s.lvl[1] : next_s.lvl[0];

			noise = ctl[range_ctrl_pkg::EXP_BIT] && ctl[range_ctrl_pkg::NOISE_BIT]
				&& (lmax < NOISE_LEVEL);
			next_s.exp_reg = ctl[range_ctrl_pkg::EXP_BIT] && (lmax < NOISE_LEVEL);
			next_s.lim_act = ctl[range_ctrl_pkg::LIM_BIT] && (lmax > LIMIT_LEVEL);
			gmax = $signed({s.regs[1], s.regs[2]});
			gmin = $signed({s.regs[3], s.regs[4]});
			tgt = next_s.lim_act ? LIMIT_CUT : 32'sh0;
			if (noise) begin
				tgt = range_ctrl_pkg::GAIN_FLOOR;
			end
			// Minimum clamp takes over from noise gating by bounding the floor.
			if (ctl[range_ctrl_pkg::MIN_BIT] && tgt < gmin) begin
				tgt = gmin;
			end
			if (ctl[range_ctrl_pkg::MAX_BIT] && tgt > gmax) begin
				tgt = gmax;
			end
			sc = next_s.exp_reg ? coef(s.regs[5], s.regs[6])
				: coef(16'h0, s.regs[0]);
			next_s.gain = 32'($signed(34'(s.gain))
				+ mul324(34'(tgt) - 34'(s.gain), sc));

			// High-pass gain scales the path only while range control runs.
			hpg = coef(s.regs[7], s.regs[8]);
			for (int c = 0; c < 2; c++) begin
				prod = mul324(34'($signed(smp[c])), hpg);
				outp[c] = range_on ? prod[23:0] : smp[c];
			end
			next_s.left = outp[1];
			next_s.right = outp[0];
			next_s.vld = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '0;
			s.regs <= range_ctrl_pkg::REG_RESET;
		end else if (CE_IN) begin
			s <= next_s;
		end
	end

	assign AWREADY_OUT = s.awrdy;
	assign WREADY_OUT = s.wrdy;
	assign BRESP_OUT = s.bresp;
	assign BVALID_OUT = s.bvalid;
	assign ARREADY_OUT = s.arrdy;
	assign RDATA_OUT = s.rdata;
	assign RRESP_OUT = s.rresp;
	assign RVALID_OUT = s.rvalid;
	assign SAMPLE_VALID_OUT = s.vld;
	assign LEFT_OUT = s.left;
	assign RIGHT_OUT = s.right;
	assign GAIN_OUT = s.gain;

endmodule // dynamic_range_ctrl_regs

// ---- tb/range_ctrl_props.sv ----
`timescale 1ns/10ps
module range_ctrl_props (
	input  wire logic        REF_CLK_IN,       // Clock
	input  wire logic        RST_N_IN,         // Reset, active low
	input  wire logic        CE_IN,            // Clock enable
	input  wire logic [11:0] AWADDR_IN,        // Write address
	input  wire logic        AWVALID_IN,       // Write address valid
	input  wire logic        AWREADY_OUT,      // Write address ready
	input  wire logic [1:0]  BRESP_OUT,        // Write response
	input  wire logic        BVALID_OUT,       // Write response valid
	input  wire logic [11:0] ARADDR_IN,        // Read address
	input  wire logic        ARVALID_IN,       // Read address valid
	input  wire logic        ARREADY_OUT,      // Read address ready
	input  wire logic [31:0] RDATA_OUT,        // Read data
	input  wire logic [1:0]  RRESP_OUT,        // Read response
	input  wire logic        RVALID_OUT,       // Read data valid
	input  wire logic        SAMPLE_VALID_IN,  // Input sample strobe
	input  wire logic        SAMPLE_VALID_OUT  // Output sample strobe
);
	logic [11:0] rd_a;

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	// The read answer carries no address, so the accepted one is kept here.
	always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rd_a <= 12'h000;
		end else if (ARVALID_IN && ARREADY_OUT) begin
			rd_a <= {ARADDR_IN[11:2], 2'h0};
		end
	end

	sequence s_sample_in;
		SAMPLE_VALID_IN && CE_IN;
	endsequence
	sequence s_gap_write;
		AWVALID_IN && AWREADY_OUT && AWADDR_IN[11:2] == 10'h1ad;
	endsequence

	a_sample_next: assert property (s_sample_in |=> SAMPLE_VALID_OUT)
		else $error("output strobe missing");
	a_sample_lone: assert property (!(SAMPLE_VALID_IN && CE_IN) |=> !SAMPLE_VALID_OUT)
		else $error("output strobe without input");
	a_upper_zero: assert property (RVALID_OUT |-> RDATA_OUT[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_ctrl_spare: assert property (RVALID_OUT && rd_a == 12'h708 |-> !RDATA_OUT[14])
		else $error("control bit 14 set");
	a_done_cause: assert property (RVALID_OUT && rd_a == 12'h708 && RDATA_OUT[15] |-> RDATA_OUT[2])
		else $error("drain flag with delay off");
	a_hi_width: assert property (RVALID_OUT && rd_a inside {12'h6ac, 12'h6b8, 12'h700, 12'h70c,
		12'h714, 12'h71c, 12'h724, 12'h72c, 12'h734} |-> RDATA_OUT[15:11] == 5'h0)
		else $error("high half wider than 11 bits");
	a_gap_read: assert property (RVALID_OUT && rd_a == 12'h6b4 |-> RRESP_OUT == 2'h2 && RDATA_OUT == 32'h0)
		else $error("gap read not refused");
	a_gap_write: assert property (s_gap_write |-> ##[1:3] (BVALID_OUT && BRESP_OUT == 2'h2))
		else $error("gap write not refused");
endmodule // range_ctrl_props

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        ce = 1'h1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, svalid = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic [23:0] left = 24'h0, right = 24'h0;
	wire  logic  awready, wready, bvalid, arready, rvalid, svout;
	wire  logic [1:0]  bresp, rresp;
	wire  logic [31:0] rdata, gain;
	wire  logic [23:0] lout, rout;
	int          mismatches = 0;
	int          check_count = 0;
	logic [43:0] rows [23] = '{44'h698_0f04_ffff, 44'h69c_fe56_ffff, 44'h6a0_cb0f_ffff,
		44'h6a4_f95b_ffff, 44'h6a8_2c3f_ffff, 44'h6ac_0000_07ff, 44'h6b0_640c_ffff,
		44'h6b8_0100_07ff, 44'h6bc_0000_ffff, 44'h700_00ff_07ff, 44'h704_fac1_ffff,
		44'h708_0080_3fff, 44'h70c_000b_07ff, 44'h710_77bf_ffff, 44'h714_000b_07ff,
		44'h718_77bf_ffff, 44'h71c_00ff_07ff, 44'h720_e1f8_ffff, 44'h724_00ff_07ff,
		44'h728_e1f8_ffff, 44'h72c_0001_07ff, 44'h730_2baf_ffff, 44'h734_0001_07ff};
	logic [5:0]  dly [4] = '{6'h00, 6'h2f, 6'h30, 6'h3f};
	logic [39:0] grow [3] = '{40'h19_f0000000, 40'h39_f95b2c3f, 40'h49_fe56cb0f};

	dynamic_range_ctrl_regs i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
		.WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
		.BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
		.ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
		.RREADY_IN(rready), .SAMPLE_VALID_IN(svalid), .LEFT_IN(left), .RIGHT_IN(right),
		.SAMPLE_VALID_OUT(svout), .LEFT_OUT(lout), .RIGHT_OUT(rout), .GAIN_OUT(gain));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// Ready levels are taken at the falling edge, where they equal what the rising edge sees.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic aw_r, w_r, b_r;
		int   n;
		@(posedge clk);
		{awaddr, wdata, wstrb} <= {a, d, s};
		{awvalid, wvalid, bready} <= 3'h7;
		n = 0;
		do begin
			@(negedge clk);
			{aw_r, w_r, b_r, r} = {awready, wready, bvalid, bresp};
			@(posedge clk);
			if (aw_r) awvalid <= 1'h0;
			if (w_r) wvalid <= 1'h0;
			n++;
		end while (!b_r && n < 60);
		bready <= 1'h0;
		if (!b_r) begin
			$display("wrong value at %0t: write response missing", $time);
			mismatches++;
			complete_run;
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_r, r_r;
		int   n;
		@(posedge clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		n = 0;
		do begin
			@(negedge clk);
			{ar_r, r_r, d, r} = {arready, rvalid, rdata, rresp};
			@(posedge clk);
			if (ar_r) arvalid <= 1'h0;
			n++;
		end while (!r_r && n < 60);
		rready <= 1'h0;
		if (!r_r) begin
			$display("wrong value at %0t: read data missing", $time);
			mismatches++;
			complete_run;
		end
	endtask

	task automatic smp(input logic [23:0] v, output logic [23:0] o);
		@(posedge clk);
		{svalid, left, right} <= {1'h1, v, ~v};
		@(posedge clk);
		svalid <= 1'h0;
		@(negedge clk);
		chk({31'h0, svout}, 32'h1, "sample strobe");
		o = lout;
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		complete_run;
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [23:0] o;
		int          len;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			rd(rows[i][43:32], d, r);
			chk(d, {16'h0, rows[i][31:16]}, "reset value");
			wr(rows[i][43:32], 32'hffffffff, 4'hf, r);
			rd(rows[i][43:32], d, r);
			chk(d, {16'h0, rows[i][15:0]}, "writable bits");
			wr(rows[i][43:32], {16'h0, rows[i][31:16]}, 4'hf, r);
		end
		$display("test registers done");
		wr(12'h6b4, 32'h00001234, 4'hf, r);
		chk({30'h0, r}, 32'h2, "gap write response");
		rd(12'h6b4, d, r);
		chk({r, d[29:0]}, 32'h80000000, "gap read");
		wr(12'h698, 32'h0000abcd, 4'h1, r);
		rd(12'h698, d, r);
		chk(d, 32'h00000fcd, "byte lane");
		$display("test bus errors done");
		foreach (dly[k]) begin
			len = (dly[k] < 6'h30) ? 8 * (dly[k] + 1) : 384;
			wr(12'h708, {18'h0, dly[k], 8'h84}, 4'hf, r);
			for (int i = 0; i < len + 4; i++) begin
				smp(24'(k * 4096 + i), o);
				if (i >= len) chk({8'h0, o}, 32'(k * 4096 + i - len), "delayed sample");
			end
		end
		rd(12'h708, d, r);
		chk(d, 32'h0000bf84, "drain flag");
		wr(12'h708, 32'h00003f04, 4'hf, r);
		smp(24'h5a5a5a, o);
		chk({8'h0, o}, 32'h005a5a5a, "bypass after drain");
		chk({8'h0, rout}, 32'h00a5a5a5, "right bypass after drain");
		wr(12'h708, 32'h00003f80, 4'hf, r);
		rd(12'h708, d, r);
		chk(d, 32'h00003f80, "drain flag cleared");
		smp(24'h3c3c3c, o);
		chk({8'h0, o}, 32'h003c3c3c, "delay field ignored");
		$display("test delay done");
		wr(12'h7f0, 32'h00000001, 4'hf, r);
		smp(24'h010000, o);
		chk({8'h0, o}, 32'h00010000, "unity high-pass gain");
		wr(12'h6b8, 32'h00000080, 4'hf, r);
		wr(12'h6bc, 32'h00004000, 4'hf, r);
		smp(24'h010000, o);
		chk({8'h0, o}, 32'h00008040, "joined gain halves");
		// Unity expander smoothing and zero peak release make the gain settle in one sample.
		wr(12'h6ac, 32'h00000100, 4'hf, r);
		wr(12'h6b0, 32'h00000000, 4'hf, r);
		for (int a = 0; a < 4; a++) begin
			wr(12'(12'h71c + 4 * a), 32'h00000000, 4'hf, r);
		end
		foreach (grow[g]) begin
			wr(12'h708, {24'h0, grow[g][39:32]}, 4'hf, r);
			repeat (3) smp(24'h000000, o);
			chk(gain, grow[g][31:0], "gain target");
		end
		rd(12'h7f4, d, r);
		chk(d, 32'h00000001, "expander region status");
		wr(12'h708, 32'h00000010, 4'hf, r);
		repeat (3) smp(24'h000000, o);
		chk({31'h0, $signed(gain) > $signed(32'hfe56cb0f)}, 32'h1, "noise off");
		wr(12'h70c, 32'h00000100, 4'hf, r);
		wr(12'h710, 32'h00000000, 4'hf, r);
		wr(12'h708, 32'h0000000a, 4'hf, r);
		smp(24'h500000, o);
		rd(12'h7f4, d, r);
		chk(d, 32'h00000002, "limiter engaged");
		$display("test gain done");
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge clk);
		rd(12'h708, d, r);
		chk(d, 32'h00000080, "control after reset");
		rd(12'h6ac, d, r);
		chk(d, 32'h00000000, "smoothing after reset");
		chk(gain, 32'h00000000, "gain after reset");
		$display("test second reset done");
		complete_run;
	end
endmodule // tb

bind dynamic_range_ctrl_regs range_ctrl_props i_props (.REF_CLK_IN(REF_CLK_IN),
	.RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .AWADDR_IN(AWADDR_IN), .AWVALID_IN(AWVALID_IN),
	.AWREADY_OUT(AWREADY_OUT), .BRESP_OUT(BRESP_OUT), .BVALID_OUT(BVALID_OUT),
	.ARADDR_IN(ARADDR_IN), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
	.RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT), .RVALID_OUT(RVALID_OUT),
	.SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT));
